// *** rtl/ssw_pkg.sv ***
package ssw_pkg;

	// clock and timing figures, times in milliseconds as printed
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned HOLD_MS_0 = 50;
	localparam int unsigned HOLD_MS_1 = 200;
	localparam int unsigned HOLD_MS_2 = 400;
	localparam int unsigned HOLD_MS_3 = 800;
	localparam int unsigned WD_MS_0 = 25;
	localparam int unsigned WD_MS_1 = 200;
	localparam int unsigned WD_MS_2 = 1400;
	localparam int unsigned HOLD_CYC_0 = HOLD_MS_0 * CYC_PER_MS;
	localparam int unsigned HOLD_CYC_1 = HOLD_MS_1 * CYC_PER_MS;
	localparam int unsigned HOLD_CYC_2 = HOLD_MS_2 * CYC_PER_MS;
	localparam int unsigned HOLD_CYC_3 = HOLD_MS_3 * CYC_PER_MS;
	localparam int unsigned WD_CYC_0 = WD_MS_0 * CYC_PER_MS;
	localparam int unsigned WD_CYC_1 = WD_MS_1 * CYC_PER_MS;
	localparam int unsigned WD_CYC_2 = WD_MS_2 * CYC_PER_MS;
	localparam logic [1:0] WD_SEL_OFF = 2'h3;

	// supply levels are 10-bit codes, 10 mV per step
	localparam int unsigned LVL_W = 10;
	localparam logic [9:0] THR1_RESET = 10'h1CC;
	localparam logic [9:0] THR2_RESET = 10'h122;
	localparam logic [9:0] THR_CLEARED = 10'h0AA;
	localparam logic [9:0] VCC_MIN_LVL = 10'h064;
	localparam logic [10:0] BATT_HYST = 11'h003;

	// register map on the bus, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_THRESH = 8'h08;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WR_MASK = 8'hE1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// two-wire bus codes
	localparam logic [6:0] TWI_MEM_ADDR = 7'h50;
	localparam logic [3:0] TWI_CTRL_PRE = 4'hB;
	localparam logic [7:0] TWI_CTRL_WORD = 8'hFF;
	localparam logic [7:0] TWI_RAISE1 = 8'h01;
	localparam logic [7:0] TWI_RAISE2 = 8'h09;
	localparam logic [7:0] TWI_CLEAR1 = 8'h03;
	localparam logic [7:0] TWI_CLEAR2 = 8'h0B;
	localparam logic [7:0] TWI_PROG_DATA = 8'h00;
	localparam logic [3:0] TWI_BITS = 4'h8;
	localparam logic [3:0] TWI_ACK_BIT = 4'h9;

	// control byte layout, bit 7 down to bit 0
	typedef struct packed {
		logic hold_select_hi;
		logic watchdog_period_hi;
		logic watchdog_period_lo;
		logic [1:0] zero;
		logic reg_write_latch;
		logic write_latch;
		logic hold_select_lo;
	} ssw_ctrl_t;

	// events seen on the two-wire bus
	typedef struct packed {
		logic start;
		logic stop;
		logic byte_done;
		logic [7:0] data;
	} ssw_twi_ev_t;

endpackage : ssw_pkg

// *** rtl/ssw_twi_rx.sv ***
`timescale 1ns/10ps
module ssw_twi_rx
	import ssw_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	// decoded events
	output ssw_twi_ev_t ev_q,
	output logic ack_slot_q
);

	logic [1:0] pin_m_q;
	logic [1:0] pin_s_q;
	logic [1:0] pin_p_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// two flops on each pin, then one more for edge detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_m_q <= 2'h3;
			pin_s_q <= 2'h3;
			pin_p_q <= 2'h3;
		end
		else
		begin
			pin_m_q <= {scl_in, sda_in};
			pin_s_q <= pin_m_q;
			pin_p_q <= pin_s_q;
		end
	end

	assign scl_rise = pin_s_q[1] && !pin_p_q[1];
	assign scl_fall = !pin_s_q[1] && pin_p_q[1];
	assign start_seen = pin_s_q[1] && pin_p_q[1] && pin_p_q[0] && !pin_s_q[0];
	assign stop_seen = pin_s_q[1] && pin_p_q[1] && !pin_p_q[0] && pin_s_q[0];

	// bit counter: eight data bits, then the acknowledge bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ack_slot_q <= 1'b0;
			ev_q <= '0;
		end
		else
		begin
			ev_q.start <= start_seen;
			ev_q.stop <= stop_seen;
			ev_q.byte_done <= 1'b0;
			if (start_seen || stop_seen)
			begin
				bit_cnt_q <= 4'h0;
				ack_slot_q <= 1'b0;
			end
			else if (scl_rise)
			begin
				if (bit_cnt_q < TWI_BITS)
					shift_q <= {shift_q[6:0], pin_s_q[0]};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
			else if (scl_fall && bit_cnt_q == TWI_BITS)
			begin
				ev_q.byte_done <= 1'b1;
				ev_q.data <= shift_q;
				ack_slot_q <= 1'b1;
			end
			else if (scl_fall && bit_cnt_q == TWI_ACK_BIT)
			begin
				ack_slot_q <= 1'b0;
				bit_cnt_q <= 4'h0;
			end
		end
	end

endmodule : ssw_twi_rx

// *** rtl/ssw_supervisor.sv ***
// Overview of operation
// - write-protect high refuses every write, bus and register alike; pin defaults low.
// - battery-active output high while backed supply runs from battery, low on main.
// - reset output asserts at its active level immediately on power application.
// - reset releases only after main supply stays above primary threshold for hold time.
// - serial bus is ignored while system reset is asserted.
// - manual reset low keeps reset asserted until release plus a full hold time.
// - main supply below primary threshold asserts reset; full hold after recovery.
// - secondary flag follows second input against secondary threshold, valid to 1V.
// - any complete bus sequence to any address restarts the watchdog.
// - two nonvolatile control bits choose the watchdog period.
// - host writes control register over serial bus; device applies new period.
// - thresholds change only through the adjustment procedure.
// - adjustment acts only while the programming voltage is present.
// - a higher threshold is stored directly, with no prior clear step.
// - no restart within the selected period drives the watchdog output low.
// - control bits 6,5 watchdog, 7,0 hold select; stop starts their store.
`timescale 1ns/10ps
module ssw_supervisor
	import ssw_pkg::*;
#(
	parameter bit ACTIVE_HIGH_RESET = 1'b0,
	parameter int unsigned HOLD_CYC0 = HOLD_CYC_0,
	parameter int unsigned HOLD_CYC1 = HOLD_CYC_1,
	parameter int unsigned HOLD_CYC2 = HOLD_CYC_2,
	parameter int unsigned HOLD_CYC3 = HOLD_CYC_3,
	parameter int unsigned WD_CYC0 = WD_CYC_0,
	parameter int unsigned WD_CYC1 = WD_CYC_1,
	parameter int unsigned WD_CYC2 = WD_CYC_2
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// control pins and digitised supply levels
	input wire logic write_protect_in,
	input wire logic manual_reset_n,
	input wire logic prog_voltage_in,
	input wire logic [9:0] vcc_level,
	input wire logic [9:0] secondary_monitor_in,
	input wire logic [9:0] battery_supply_in,
	// supervisor outputs
	output logic sys_reset_out,
	output logic primary_supply_fail,
	output logic secondary_supply_fail,
	output logic watchdog_expired_out_n,
	output logic battery_active_out
);

	typedef enum logic [2:0] {RST_ASSERT = 3'b001, RST_HOLD = 3'b010, RST_RUN = 3'b100} ssw_rst_t;
	typedef enum logic [4:0] {TW_IDLE = 5'b00001, TW_SLAVE = 5'b00010, TW_WORD = 5'b00100,
		TW_DATA = 5'b01000, TW_DONE = 5'b10000} ssw_tw_t;

	localparam int unsigned SYNC_W = 3 + 3 * LVL_W;

	generate
		if (HOLD_CYC0 == 0 || HOLD_CYC1 == 0 || HOLD_CYC2 == 0 || HOLD_CYC3 == 0 ||
			WD_CYC0 == 0 || WD_CYC1 == 0 || WD_CYC2 == 0)
		begin : g_bad_count
			$error("ssw_supervisor: hold and watchdog counts must be at least one");
		end
	endgenerate

	logic [SYNC_W-1:0] sync_m_q;
	logic [SYNC_W-1:0] sync_s_q;
	logic wp;
	logic mr_n;
	logic vp;
	logic [9:0] vcc;
	logic [9:0] v2;
	logic [9:0] vbat;
	ssw_ctrl_t ctrl_q;
	logic [9:0] thr1_q;
	logic [9:0] thr2_q;
	ssw_rst_t rst_q;
	logic [31:0] hold_cnt_q;
	logic [31:0] hold_lim;
	logic [31:0] wd_cnt_q;
	logic [31:0] wd_lim;
	logic vcc_ok;
	logic vcc_alive;
	logic rst_bad;
	logic rst_active;
	ssw_twi_ev_t ev;
	logic ack_slot;
	ssw_tw_t tw_q;
	logic tw_ctrl_q;
	logic [7:0] tw_word_q;
	logic [7:0] tw_data_q;
	logic ack_q;
	logic framed_q;
	logic wd_restart;
	logic commit;
	logic ctrl_bus_wr;

	// every pin and level from outside passes two flops first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_m_q <= '0;
			sync_s_q <= '0;
		end
		else
		begin
			sync_m_q <= {write_protect_in, manual_reset_n, prog_voltage_in,
				vcc_level, secondary_monitor_in, battery_supply_in};
			sync_s_q <= sync_m_q;
		end
	end

	assign {wp, mr_n, vp, vcc, v2, vbat} = sync_s_q;
	assign vcc_ok = vcc > thr1_q;
	assign vcc_alive = vcc >= VCC_MIN_LVL;
	assign rst_bad = !vcc_ok || !mr_n;
	assign rst_active = rst_q != RST_RUN;

	// hold time picked by bits 7 and 0 of the control byte
	always_comb
	begin
		case ({ctrl_q.hold_select_hi, ctrl_q.hold_select_lo})
			2'h0: hold_lim = HOLD_CYC0;
			2'h1: hold_lim = HOLD_CYC1;
			2'h2: hold_lim = HOLD_CYC2;
			default: hold_lim = HOLD_CYC3;
		endcase
	end

	// reset sequencer; power-up enters the asserted state at once
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rst_q <= RST_ASSERT;
			hold_cnt_q <= '0;
		end
		else
		begin
			case (rst_q)
				RST_ASSERT:
				begin
					hold_cnt_q <= '0;
					if (!rst_bad)
						rst_q <= RST_HOLD;
				end
				RST_HOLD:
				begin
					hold_cnt_q <= hold_cnt_q + 32'h1;
					if (rst_bad)
						rst_q <= RST_ASSERT;
					else if (hold_cnt_q >= hold_lim - 32'h1)
						rst_q <= RST_RUN;
				end
				RST_RUN:
				begin
					if (rst_bad)
						rst_q <= RST_ASSERT;
				end
				default: rst_q <= RST_ASSERT;
			endcase
		end
	end

	// pin levels; below the 1V level the secondary flag keeps its last answer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sys_reset_out <= ACTIVE_HIGH_RESET;
			primary_supply_fail <= 1'b1;
			secondary_supply_fail <= 1'b0;
			battery_active_out <= 1'b0;
		end
		else
		begin
			sys_reset_out <= ACTIVE_HIGH_RESET ? rst_active : !rst_active;
			if (!vcc_ok)
				primary_supply_fail <= 1'b1;
			else if (rst_q == RST_HOLD && !rst_bad && hold_cnt_q >= hold_lim - 32'h1)
				primary_supply_fail <= 1'b0;
			if (vcc_alive)
				secondary_supply_fail <= !(v2 > thr2_q);
			// hysteresis around the battery level avoids chattering between supplies
			if (vcc_ok)
				battery_active_out <= 1'b0;
			else if ({1'b0, vcc} + BATT_HYST < {1'b0, vbat})
				battery_active_out <= 1'b1;
			else if ({1'b0, vcc} > {1'b0, vbat} + BATT_HYST)
				battery_active_out <= 1'b0;
		end
	end

	ssw_twi_rx u_twi_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ev_q(ev),
		.ack_slot_q(ack_slot)
	);

	// byte decoder; while reset is asserted the bus is not listened to
	always_ff @(posedge aclk)
	begin
		if (!aresetn || rst_active)
		begin
			tw_q <= TW_IDLE;
			tw_ctrl_q <= 1'b0;
			tw_word_q <= 8'h00;
			tw_data_q <= 8'h00;
			ack_q <= 1'b0;
			framed_q <= 1'b0;
		end
		else
		begin
			if (!ack_slot)
				ack_q <= 1'b0;
			if (ev.start)
			begin
				tw_q <= TW_SLAVE;
				framed_q <= 1'b1;
			end
			else if (ev.stop)
			begin
				tw_q <= TW_IDLE;
				framed_q <= 1'b0;
			end
			else if (ev.byte_done)
			begin
				case (tw_q)
					TW_SLAVE:
					begin
						tw_ctrl_q <= ev.data[7:4] == TWI_CTRL_PRE;
						if (!ev.data[0] && (ev.data[7:1] == TWI_MEM_ADDR || ev.data[7:4] == TWI_CTRL_PRE))
						begin
							ack_q <= 1'b1;
							tw_q <= TW_WORD;
						end
						else
							tw_q <= TW_IDLE;
					end
					TW_WORD:
					begin
						tw_word_q <= ev.data;
						ack_q <= 1'b1;
						tw_q <= TW_DATA;
					end
					TW_DATA:
					begin
						tw_data_q <= ev.data;
						ack_q <= 1'b1;
						tw_q <= TW_DONE;
					end
					TW_DONE: tw_q <= TW_DONE; // one data byte only, later ones unanswered
					default: tw_q <= TW_IDLE;
				endcase
			end
		end
	end

	// acknowledge drives the line low; the output itself is always low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sda_oe <= 1'b0;
		else
			sda_oe <= ack_slot && ack_q && !rst_active;
	end
	assign sda_out = 1'b0;

	assign commit = ev.stop && tw_q == TW_DONE && !wp;
	assign wd_restart = ev.stop && framed_q;
	assign ctrl_bus_wr = s_axi_awready && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0] && !wp;

	// control byte: nonvolatile bits taken from the serial bus or the register bus
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_q <= CTRL_RESET;
		else if (commit && tw_ctrl_q && tw_word_q == TWI_CTRL_WORD)
			ctrl_q <= tw_data_q & CTRL_WR_MASK;
		else if (ctrl_bus_wr)
			ctrl_q <= s_axi_wdata[7:0] & CTRL_WR_MASK;
	end

	// threshold cells move only by the programming procedure
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			thr1_q <= THR1_RESET;
			thr2_q <= THR2_RESET;
		end
		else if (commit && !tw_ctrl_q && vp && tw_data_q == TWI_PROG_DATA)
		begin
			// a raise below the stored value is ignored; clear first to go lower
			if (tw_word_q == TWI_RAISE1 && vcc > thr1_q)
				thr1_q <= vcc;
			else if (tw_word_q == TWI_RAISE2 && v2 > thr2_q)
				thr2_q <= v2;
			else if (tw_word_q == TWI_CLEAR1)
				thr1_q <= THR_CLEARED;
			else if (tw_word_q == TWI_CLEAR2)
				thr2_q <= THR_CLEARED;
		end
	end

	// watchdog period from bits 6 and 5, the top code turns it off
	always_comb
	begin
		case ({ctrl_q.watchdog_period_hi, ctrl_q.watchdog_period_lo})
			2'h0: wd_lim = WD_CYC0;
			2'h1: wd_lim = WD_CYC1;
			2'h2: wd_lim = WD_CYC2;
			default: wd_lim = 32'h0;
		endcase
	end

	// watchdog counter; held clear during reset so the host gets a full period
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wd_cnt_q <= '0;
			watchdog_expired_out_n <= 1'b1;
		end
		else if (rst_active || wd_restart ||
			{ctrl_q.watchdog_period_hi, ctrl_q.watchdog_period_lo} == WD_SEL_OFF)
		begin
			wd_cnt_q <= '0;
			watchdog_expired_out_n <= 1'b1;
		end
		else if (wd_cnt_q >= wd_lim - 32'h1)
			watchdog_expired_out_n <= 1'b0;
		else
			wd_cnt_q <= wd_cnt_q + 32'h1;
	end

	// register bus write: both channels taken together, one response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			else if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awready)
			begin
				s_axi_bvalid <= 1'b1;
				if (s_axi_awaddr != REG_CTRL && s_axi_awaddr != REG_STATUS && s_axi_awaddr != REG_THRESH)
					s_axi_bresp <= RESP_DECERR;
				else if (s_axi_awaddr == REG_CTRL && !wp)
					s_axi_bresp <= RESP_OKAY;
				else
					s_axi_bresp <= RESP_SLVERR;
			end
		end
	end

	// register bus read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid)
				s_axi_arready <= 1'b1;
			if (s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					REG_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
					REG_STATUS: s_axi_rdata <= {21'h0, tw_q != TW_IDLE, wp, vp, !mr_n, rst_q,
						battery_active_out, !watchdog_expired_out_n, secondary_supply_fail, primary_supply_fail};
					REG_THRESH: s_axi_rdata <= {6'h0, thr2_q, 6'h0, thr1_q};
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= RESP_DECERR;
					end
				endcase
			end
		end
	end

endmodule : ssw_supervisor

// *** verification/ssw_asserts.sv ***
`timescale 1ns/10ps
module ssw_asserts
	import ssw_pkg::*;
#(
	parameter bit ACTIVE_HIGH_RESET = 1'b0,
	parameter int unsigned HOLD_CYC0 = HOLD_CYC_0,
	parameter int unsigned WD_CYC0 = WD_CYC_0
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus response
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	// pins in
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic write_protect_in,
	input wire logic manual_reset_n,
	input wire logic [9:0] vcc_level,
	input wire logic [9:0] secondary_monitor_in,
	input wire logic [9:0] battery_supply_in,
	// supervisor outputs
	input wire logic sys_reset_out,
	input wire logic primary_supply_fail,
	input wire logic secondary_supply_fail,
	input wire logic watchdog_expired_out_n,
	input wire logic battery_active_out
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [31:0] mr_ok_q;
	logic [31:0] quiet_q;
	logic scl_q;
	logic sda_q;
	logic rst_on;

	// output at its active level, whichever polarity is built
	assign rst_on = sys_reset_out == ACTIVE_HIGH_RESET;

	// cycles since manual reset was last low; pin sync only delays the design, so this is a safe lower bound
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !manual_reset_n)
			mr_ok_q <= '0;
		else if (mr_ok_q != '1)
			mr_ok_q <= mr_ok_q + 1'b1;
	end

	// cycles since the last stop outside system reset; stops inside it are ignored by the device
	always_ff @(posedge aclk)
	begin
		scl_q <= scl_in;
		sda_q <= sda_in;
		if (!aresetn || (scl_in && scl_q && sda_in && !sda_q && !rst_on))
			quiet_q <= '0;
		else
			quiet_q <= quiet_q + 1'b1;
	end

	a_power_on_active: assert property ($rose(aresetn) |-> rst_on)
		else $error("reset output idle right after power-up");
	a_manual_holds: assert property (!manual_reset_n [*5] |-> rst_on)
		else $error("reset output idle while manual reset held");
	a_release_hold: assert property ($fell(rst_on) |-> mr_ok_q >= HOLD_CYC0)
		else $error("reset released before the hold time");
	a_low_supply: assert property ((vcc_level < THR_CLEARED) [*5] |-> rst_on && primary_supply_fail)
		else $error("low supply without reset and fail flag");
	a_wp_refused: assert property (s_axi_bvalid && write_protect_in && $past(write_protect_in, 4)
		|-> s_axi_bresp != RESP_OKAY)
		else $error("write accepted while protected");
	a_sec_fail: assert property ((secondary_monitor_in < THR_CLEARED && vcc_level >= VCC_MIN_LVL) [*5]
		|-> secondary_supply_fail)
		else $error("secondary fail flag missing");
	a_battery_active_out: assert property ((vcc_level < THR_CLEARED && {1'b0, vcc_level} + 11'h010 < {1'b0, battery_supply_in}) [*5]
		|-> battery_active_out)
		else $error("battery output low on battery");
	a_batt_off: assert property (({1'b0, vcc_level} > {1'b0, battery_supply_in} + 11'h010) [*5]
		|-> !battery_active_out)
		else $error("battery output high on main supply");
	a_wd_not_early: assert property ($fell(watchdog_expired_out_n) |-> quiet_q >= WD_CYC0)
		else $error("watchdog fired before its period");
endmodule : ssw_asserts

bind ssw_supervisor ssw_asserts #(.ACTIVE_HIGH_RESET(ACTIVE_HIGH_RESET), .HOLD_CYC0(HOLD_CYC0), .WD_CYC0(WD_CYC0))
	u_chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .scl_in, .sda_in, .write_protect_in, .manual_reset_n,
	.vcc_level, .secondary_monitor_in, .battery_supply_in, .sys_reset_out, .primary_supply_fail,
	.secondary_supply_fail, .watchdog_expired_out_n, .battery_active_out);

// *** verification/ssw_twi_host.sv ***
`timescale 1ns/10ps
module ssw_twi_host
(
	// bus lines
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	// idle: both lines released to the pull-up; the clock stands still between frames
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// one 200 ns bit: low 125 ns so the device ack settles, high 75 ns
	task automatic bit_slot(input logic b, output logic seen);
		scl = 1'b0;
		#50 sda_drv = b;
		#75 scl = 1'b1;
		seen = sda;
		#75;
	endtask : bit_slot

	// stop: data rises while the clock is high
	task automatic stop();
		scl = 1'b0;
		#50 sda_drv = 1'b0;
		#75 scl = 1'b1;
		#75 sda_drv = 1'b1;
		#100;
	endtask : stop

	// start, n bytes msb first each with an ack slot, stop; acks bit set = byte acknowledged
	task automatic frame(input logic [23:0] bytes, input int n, output logic [2:0] acks);
		logic s;
		acks = '0;
		// start 5 ns past the clock edge so no line moves while the design samples it
		#5 sda_drv = 1'b0;
		#100;
		for (int i = 0; i < n; i++)
		begin
			for (int j = 23 - 8 * i; j > 15 - 8 * i; j--)
				bit_slot(bytes[j], s);
			bit_slot(1'b1, s);
			acks[2 - i] = !s;
		end
		stop();
	endtask : frame

	// shortest restart: start, clock low, clock high, stop
	task automatic kick();
		#5 sda_drv = 1'b0;
		#100 scl = 1'b0;
		#100 scl = 1'b1;
		#100 sda_drv = 1'b1;
		#100;
	endtask : kick
endmodule : ssw_twi_host

// *** verification/supply_supervisor_watchdog_tb.sv ***
`timescale 1ns/10ps
module supply_supervisor_watchdog_tb
	import ssw_pkg::*;
;
	typedef struct {
		bit tw;
		logic [23:0] fr;
		logic prog;
		logic wp;
		logic [9:0] vcc;
		logic [7:0] a;
		logic wr;
		logic [31:0] d;
		logic [31:0] exp;
		logic [1:0] resp;
	} ssw_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = '0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic scl_in;
	logic sda_drv;
	logic sda_in;
	logic sda_out;
	logic sda_oe;
	logic write_protect_in = 1'b0;
	logic manual_reset_n = 1'b1;
	logic prog_voltage_in = 1'b0;
	logic [9:0] vcc_level = 10'h3FF;
	logic [9:0] secondary_monitor_in = 10'h200;
	logic [9:0] battery_supply_in = 10'h1E0;
	logic sys_reset_out;
	logic primary_supply_fail;
	logic secondary_supply_fail;
	logic watchdog_expired_out_n;
	logic battery_active_out;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	int n;
	logic [2:0] acks;
	logic [31:0] rd;
	logic [1:0] rs;
	ssw_row_t rows[15] = '{
		'{'0, '0, '0, '0, 10'h3FF, REG_CTRL, '1, 32'hFF, '0, RESP_OKAY},
		'{'0, '0, '0, '0, 10'h3FF, REG_CTRL, '0, '0, 32'hE1, RESP_OKAY},
		'{'0, '0, '0, '0, 10'h3FF, REG_THRESH, '0, '0, 32'h0122_01CC, RESP_OKAY},
		'{'0, '0, '0, '0, 10'h3FF, REG_STATUS, '1, 32'h5, '0, RESP_SLVERR},
		'{'0, '0, '0, '0, 10'h3FF, 8'h0C, '1, 32'h5, '0, RESP_DECERR},
		'{'0, '0, '0, '0, 10'h3FF, 8'h0C, '0, '0, '0, RESP_DECERR},
		'{'0, '0, '0, '1, 10'h3FF, REG_CTRL, '1, '0, '0, RESP_SLVERR},
		'{'0, '0, '0, '0, 10'h3FF, REG_CTRL, '0, '0, 32'hE1, RESP_OKAY},
		'{'0, '0, '0, '0, 10'h3FF, REG_CTRL, '1, '0, '0, RESP_OKAY},
		'{'1, 24'hB0FF20, '0, '0, 10'h3FF, REG_CTRL, '0, '0, 32'h20, RESP_OKAY},
		'{'1, 24'hB0FF41, '0, '1, 10'h3FF, REG_CTRL, '0, '0, 32'h20, RESP_OKAY},
		'{'1, 24'hA00100, '0, '0, 10'h1E0, REG_THRESH, '0, '0, 32'h0122_01CC, RESP_OKAY},
		'{'1, 24'hA00100, '1, '0, 10'h1E0, REG_THRESH, '0, '0, 32'h0122_01E0, RESP_OKAY},
		'{'1, 24'hA00300, '1, '0, 10'h3FF, REG_THRESH, '0, '0, 32'h0122_00AA, RESP_OKAY},
		'{'1, 24'hA00100, '1, '0, 10'h1D0, REG_THRESH, '0, '0, 32'h0122_01D0, RESP_OKAY}
	};

	// open-drain data line with pull-up: low when either party pulls
	assign sda_in = sda_drv & (!sda_oe | sda_out);

	ssw_supervisor #(.HOLD_CYC0(20), .HOLD_CYC1(40), .HOLD_CYC3(80), .WD_CYC0(30), .WD_CYC1(50))
		dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in, .sda_in, .sda_out, .sda_oe,
		.write_protect_in, .manual_reset_n, .prog_voltage_in, .vcc_level, .secondary_monitor_in, .battery_supply_in,
		.sys_reset_out, .primary_supply_fail, .secondary_supply_fail, .watchdog_expired_out_n, .battery_active_out);
	ssw_twi_host host (.scl(scl_in), .sda_drv, .sda(sda_in));

	// 40 MHz clock
	always #12.5 aclk = ~aclk;

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			mismatches++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask : tick

	// address and data offered together, each dropped once taken; starts on a fresh edge so bready never toggles twice
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// cycles until the active-low system reset lets go
	task automatic wait_run(output int k);
		k = 0;
		while (sys_reset_out !== 1'b1 && k < 2000)
		begin
			@(posedge aclk);
			k++;
		end
	endtask : wait_run

	// main sequence
	initial
	begin
		tick(8);
		aresetn <= 1'b1;
		tick(1);
		check("reset at power-up", sys_reset_out, 1'b0);
		wait_run(n);
		check("power-up hold", n >= 20 && n < 40, 1'b1);
		foreach (rows[i])
		begin
			vcc_level <= rows[i].vcc;
			prog_voltage_in <= rows[i].prog;
			write_protect_in <= rows[i].wp;
			tick(4);
			rd = rows[i].exp;
			if (rows[i].tw)
			begin
				host.frame(rows[i].fr, 3, acks);
				// a raised threshold pulls reset a few cycles after the stop; let it show first
				tick(4);
				vcc_level <= 10'h3FF;
				prog_voltage_in <= 1'b0;
				write_protect_in <= 1'b0;
				wait_run(n);
				axi_rd(rows[i].a, rd, rs);
			end
			else if (rows[i].wr)
				axi_wr(rows[i].a, rows[i].d, rs);
			else
				axi_rd(rows[i].a, rd, rs);
			check("row data", rd, rows[i].exp);
			check("row response", rs, rows[i].resp);
		end
		// period 01 selected by the last control write
		host.kick();
		n = 0;
		while (watchdog_expired_out_n === 1'b1 && n < 300)
		begin
			tick(1);
			n++;
		end
		check("watchdog period", n >= 45 && n <= 60, 1'b1);
		host.kick();
		tick(8);
		check("watchdog restart", watchdog_expired_out_n, 1'b1);
		// bus frame during manual reset must be ignored
		manual_reset_n <= 1'b0;
		tick(6);
		check("manual reset", sys_reset_out, 1'b0);
		host.frame(24'hB0FF00, 3, acks);
		check("acks in reset", acks, 3'h0);
		tick(1);
		manual_reset_n <= 1'b1;
		wait_run(n);
		check("manual hold", n >= 20, 1'b1);
		axi_rd(REG_CTRL, rd, rs);
		check("control kept", rd, 32'h20);
		// brownout, then a dip in mid-hold restarts the hold
		vcc_level <= 10'h1C0;
		tick(6);
		check("brownout reset", {sys_reset_out, primary_supply_fail}, 2'h1);
		vcc_level <= 10'h3FF;
		tick(10);
		vcc_level <= 10'h1C0;
		tick(4);
		vcc_level <= 10'h3FF;
		wait_run(n);
		check("hold restarted", n >= 20, 1'b1);
		// secondary flag and battery switch
		secondary_monitor_in <= 10'h050;
		tick(6);
		check("secondary fail", secondary_supply_fail, 1'b1);
		vcc_level <= 10'h050;
		tick(6);
		check("battery on", {battery_active_out, secondary_supply_fail}, 2'h3);
		vcc_level <= 10'h3FF;
		secondary_monitor_in <= 10'h200;
		tick(6);
		check("battery off", {battery_active_out, secondary_supply_fail}, 2'h0);
		finish_test();
	end
endmodule : supply_supervisor_watchdog_tb
